// ===== pkg/cftc_pkg.sv
/*
  Constants, field layout and types shared by the camera frame trigger block.
  Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package cftc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SET_W = 24;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_SHUT = 8'h08;
  localparam logic [7:0] OFF_LAT = 8'h0c;
  localparam logic [7:0] OFF_RATE = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_FRAMES = 8'h18;

  localparam int CTL_COMPAT = 0;
  localparam int CTL_GATE = 1;
  localparam int CTL_SRC_SW = 2;
  localparam int CTL_POL_FALL = 3;
  localparam int CTL_PULSE = 4;
  localparam int CTL_CONT = 5;
  localparam int CTL_RATE_ON = 6;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  localparam int CMD_BEGIN = 0;
  localparam int CMD_END = 1;
  localparam int CMD_SWTRIG = 2;

  localparam int STA_ACQ = 0;
  localparam int STA_WAIT = 1;
  localparam int STA_EXP = 2;
  localparam int STA_RDY = 3;

  typedef enum logic [1:0] {
    CFTC_IDLE,
    CFTC_WAIT,
    CFTC_DELAY,
    CFTC_EXPOSE
  } cftc_phase_t;

endpackage

// ===== pkg/cftc_ifs.sv
/*
  Interfaces between the trigger controller and its helper modules.
  Assumes all parties run on the same clock.
*/
`timescale 1ns/10ps
interface cftc_tmr_if #(parameter int W = 24);
  logic start;
  logic [W-1:0] count;
  logic busy;
  logic done;
  modport ctl(output start, output count, input busy, input done);
  modport tmr(input start, input count, output busy, output done);
endinterface

interface cftc_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src(output level, output rise, output fall);
  modport dst(input level, input rise, input fall);
endinterface

// ===== rtl/cftc_sync.sv
/*
  Three-stage synchroniser and edge detector for the trigger pin.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/10ps
module cftc_sync (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic pin,
  cftc_pin_if.src p
);
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic rise;
    logic fall;
  } cftc_sync_state_t;

  cftc_sync_state_t st;
  cftc_sync_state_t next_st;

  // A change is taken only once the second and third stages agree.
  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[1:0], pin};
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.sh[1] == st.sh[2] && st.sh[2] != st.lvl) begin
      next_st.lvl = st.sh[2];
      next_st.rise = st.sh[2];
      next_st.fall = ~st.sh[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign p.level = st.lvl;
  assign p.rise = st.rise;
  assign p.fall = st.fall;
endmodule

// ===== rtl/cftc_timer.sv
/*
  Microsecond down-counter: loads on start, pulses done when it runs out.
  Assumes start is a one-cycle strobe and the count is in microseconds.
*/
`timescale 1ns/10ps
module cftc_timer
  import cftc_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic ref_clk,
  input wire logic srst,
  cftc_tmr_if.tmr t
);
  localparam int PW = $clog2(TICK_CYCLES);

  // The prescaler restarts with every load, so a count of N lasts N full
  // microseconds; a shared free-running tick would cut the first one short.
  typedef struct packed {
    logic busy;
    logic done;
    logic [PW-1:0] pre;
    logic [W-1:0] cnt;
  } cftc_timer_state_t;

  cftc_timer_state_t st;
  cftc_timer_state_t next_st;

  // A load of N ends after N ticks; a load of zero ends on the next cycle.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (t.start) begin
      next_st.busy = 1'b1;
      next_st.cnt = t.count;
      next_st.pre = '0;
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else if (st.pre == PW'(TICK_CYCLES - 1)) begin
        next_st.pre = '0;
        next_st.cnt = st.cnt - 1'b1;
      end else begin
        next_st.pre = st.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign t.busy = st.busy;
  assign t.done = st.done;
endmodule

// ===== rtl/cftc_top.sv
/*
  Camera frame trigger controller: APB registers, trigger selection,
  latency, internal trigger generation and exposure sequencing.
  Assumes an APB master on ref_clk and an asynchronous trigger pin.
*/
`timescale 1ns/10ps
module cftc_top
  import cftc_pkg::*;
#(
  parameter int W = SET_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic external_frame_trigger_in,
  input wire logic [W-1:0] max_rate_period_us,
  output logic exposure_active,
  output logic trigger_ready_out,
  output logic frame_start
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] ctrl;
    logic [W-1:0] shutter;
    logic [W-1:0] latency;
    logic [W-1:0] rate;
    logic [31:0] frames;
    cftc_phase_t phase;
    logic acq;
    logic gen_on;
    logic first;
    logic min_done;
    logic dly_start;
    logic exp_start;
    logic rate_start;
    logic exp_out;
    logic rdy_out;
    logic fs_out;
  } cftc_top_state_t;

  cftc_top_state_t st;
  cftc_top_state_t next_st;

  logic cmd_begin;
  logic cmd_end;
  logic cmd_sw;
  logic ext_on;
  logic use_line;
  logic pulse_mode;
  logic hw_trig;
  logic sw_trig;
  logic int_trig;
  logic take;
  logic line_idle;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [W-1:0] eff_period;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  cftc_pin_if pin_if ();
  cftc_tmr_if #(.W(W)) dly_if ();
  cftc_tmr_if #(.W(W)) exp_if ();
  cftc_tmr_if #(.W(W)) rate_if ();

  cftc_sync u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(external_frame_trigger_in),
    .p(pin_if)
  );

  cftc_timer #(.W(W)) u_dly (
    .ref_clk(ref_clk),
    .srst(srst),
    .t(dly_if)
  );

  cftc_timer #(.W(W)) u_exp (
    .ref_clk(ref_clk),
    .srst(srst),
    .t(exp_if)
  );

  cftc_timer #(.W(W)) u_rate (
    .ref_clk(ref_clk),
    .srst(srst),
    .t(rate_if)
  );

  function automatic logic [W-1:0] umax(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    umax = (a > b) ? a : b;
  endfunction

  // A rate is held as a frame period in microseconds, so a higher rate
  // is a smaller value and the clamp is a maximum against the floor.
  assign eff_period = st.ctrl[CTL_RATE_ON] ?
                      umax(st.rate, max_rate_period_us) :
                      max_rate_period_us;

  assign dly_if.start = st.dly_start;
  assign dly_if.count = st.latency;
  assign exp_if.start = st.exp_start;
  assign exp_if.count = st.shutter;
  assign rate_if.start = st.rate_start;
  assign rate_if.count = eff_period;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_val[7:0] = st.ctrl;
      OFF_CMD: rd_val = '0;
      OFF_SHUT: rd_val[W-1:0] = st.shutter;
      OFF_LAT: rd_val[W-1:0] = st.latency;
      OFF_RATE: rd_val[W-1:0] = st.rate;
      OFF_STAT: begin
        rd_val[STA_ACQ] = st.acq;
        rd_val[STA_WAIT] = (st.phase == CFTC_WAIT);
        rd_val[STA_EXP] = st.exp_out;
        rd_val[STA_RDY] = st.rdy_out;
      end
      OFF_FRAMES: rd_val = st.frames;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    cmd_begin = 1'b0;
    cmd_end = 1'b0;
    cmd_sw = 1'b0;
    int_trig = 1'b0;
    take = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.dly_start = 1'b0;
    next_st.exp_start = 1'b0;
    next_st.rate_start = 1'b0;
    next_st.fs_out = 1'b0;

    // One wait state: pready rises in the second access cycle.
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~rd_hit;
      next_st.prdata = rd_val;
    end
    if (psel && penable && st.pready && pwrite) begin
      case (paddr)
        OFF_CTRL: next_st.ctrl = pwdata[7:0];
        OFF_CMD: begin
          cmd_begin = pwdata[CMD_BEGIN];
          cmd_end = pwdata[CMD_END];
          cmd_sw = pwdata[CMD_SWTRIG];
        end
        OFF_SHUT: next_st.shutter = pwdata[W-1:0];
        OFF_LAT: next_st.latency = pwdata[W-1:0];
        OFF_RATE: next_st.rate = pwdata[W-1:0];
        default: ;
      endcase
    end

    // Trigger sources.
    ext_on = st.ctrl[CTL_GATE];
    use_line = ext_on && !st.ctrl[CTL_SRC_SW];
    pulse_mode = st.ctrl[CTL_PULSE] && use_line;
    hw_trig = use_line &&
              (st.ctrl[CTL_POL_FALL] ? pin_if.fall : pin_if.rise);
    sw_trig = ext_on && st.ctrl[CTL_SRC_SW] && cmd_sw;
    line_idle = st.ctrl[CTL_POL_FALL] ? pin_if.level : ~pin_if.level;

    // Acquisition begin and end. The first internal trigger is held one
    // cycle so that it meets the waiting state rather than idle.
    if (cmd_begin && !st.acq) begin
      next_st.acq = 1'b1;
      next_st.first = ~ext_on;
      next_st.gen_on = ~ext_on && st.ctrl[CTL_CONT];
    end
    if (st.first && st.phase == CFTC_WAIT) begin
      int_trig = 1'b1;
      next_st.first = 1'b0;
      next_st.rate_start = st.gen_on;
    end
    if (st.gen_on && !ext_on && rate_if.done) begin
      int_trig = 1'b1;
      next_st.rate_start = 1'b1;
    end
    if (cmd_end) begin
      next_st.acq = 1'b0;
      next_st.gen_on = 1'b0;
      next_st.first = 1'b0;
    end

    // Frame sequencing. Triggers outside the waiting state are dropped.
    case (st.phase)
      CFTC_IDLE: begin
        if (st.acq) begin
          next_st.phase = CFTC_WAIT;
        end
      end
      CFTC_WAIT: begin
        if (!st.acq) begin
          next_st.phase = CFTC_IDLE;
        end else if (hw_trig && st.latency != '0) begin
          next_st.phase = CFTC_DELAY;
          next_st.dly_start = 1'b1;
        end else if (hw_trig || sw_trig || int_trig) begin
          take = 1'b1;
        end
      end
      CFTC_DELAY: begin
        if (dly_if.done) begin
          take = 1'b1;
        end
      end
      CFTC_EXPOSE: begin
        if (exp_if.done) begin
          next_st.min_done = 1'b1;
        end
        if (pulse_mode ? line_idle : exp_if.done) begin
          next_st.phase = st.ctrl[CTL_CONT] ? CFTC_WAIT : CFTC_IDLE;
          if (!st.ctrl[CTL_CONT]) begin
            next_st.acq = 1'b0;
            next_st.gen_on = 1'b0;
          end
        end
      end
      default: next_st.phase = CFTC_IDLE;
    endcase

    // The shutter timer runs in both modes: in pulse mode it only marks
    // the shortest expected exposure for the ready output.
    if (take) begin
      next_st.phase = CFTC_EXPOSE;
      next_st.exp_start = 1'b1;
      next_st.fs_out = 1'b1;
      next_st.min_done = 1'b0;
      next_st.frames = st.frames + 32'h0000_0001;
    end

    next_st.exp_out = (next_st.phase == CFTC_EXPOSE);
    next_st.rdy_out = (next_st.phase == CFTC_WAIT) ||
                      (next_st.phase == CFTC_EXPOSE && pulse_mode &&
                       next_st.min_done);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.phase <= CFTC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign exposure_active = st.exp_out;
  assign trigger_ready_out = st.rdy_out;
  assign frame_start = st.fs_out;

endmodule

// ===== tb/cftc_trig_src.sv
/*
  Model of the external trigger source driving the frame trigger pin.
  Assumes the bench raises fire for one cycle to launch one pulse.
*/
`timescale 1ns/10ps
module cftc_trig_src (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic pol_fall,
  input wire logic [15:0] hi_len,
  output logic line
);
  logic [15:0] left = 16'h0000;
  always_ff @(posedge ref_clk) begin
    if (fire) begin
      left <= hi_len;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  // The pin idles at the inactive level, so a polarity change also moves the pin and makes an edge on it.
  assign line = (left != 16'h0000) ^ pol_fall;
endmodule

// ===== tb/cftc_props.sv
/*
  Concurrent checks on the frame trigger block ports.
  Assumes it is bound into cftc_top and sees register writes on APB.
*/
`timescale 1ns/10ps
module cftc_props
  import cftc_pkg::*;
#(
  parameter int W = SET_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic external_frame_trigger_in,
  input wire logic [W-1:0] max_rate_period_us,
  input wire logic exposure_active,
  input wire logic trigger_ready_out,
  input wire logic frame_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic wr;
  logic seen;
  logic [7:0] ctl;
  logic [W-1:0] rate;
  logic [W-1:0] eff;
  logic [31:0] gap;
  logic [31:0] eff_cyc;
  logic [3:0] since;
  assign wr = psel && penable && pready && pwrite;
  assign eff = (ctl[CTL_RATE_ON] && rate > max_rate_period_us) ? rate : max_rate_period_us;
  assign eff_cyc = 32'(eff) * TICK_CYCLES;
  // A shadow of the control word lets the checks know the mode in force.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl <= CTRL_RESET;
      rate <= '0;
      gap <= 32'h0;
      seen <= 1'b0;
      since <= 4'h0;
    end else begin
      if (wr && paddr == OFF_CTRL) ctl <= pwdata[7:0];
      if (wr && paddr == OFF_RATE) rate <= pwdata[W-1:0];
      gap <= frame_start ? 32'h0 : gap + 32'h1;
      seen <= wr ? 1'b0 : (seen | frame_start);
      since <= (wr && paddr == OFF_CMD) ? 4'h0 : since + {3'h0, frame_start && since != 4'hf};
    end
  end
  logic pls;
  assign pls = ctl[CTL_PULSE] && ctl[CTL_GATE] && !ctl[CTL_SRC_SW];
  sequence s_rel_rise;
    exposure_active && pls && !ctl[CTL_POL_FALL] && $fell(external_frame_trigger_in);
  endsequence
  sequence s_rel_fall;
    exposure_active && pls && ctl[CTL_POL_FALL] && $rose(external_frame_trigger_in);
  endsequence
  chk_start_one_cycle: assert property (frame_start |=> !frame_start)
    else $error("frame start wider than one cycle");
  chk_start_exposes: assert property (frame_start |-> ##[0:2] exposure_active)
    else $error("accepted trigger without exposure");
  chk_no_start_busy: assert property (frame_start |-> !$past(exposure_active))
    else $error("trigger taken during exposure");
  chk_ready_drops: assert property (frame_start |=> !trigger_ready_out)
    else $error("ready still high after trigger");
  chk_pulse_rise_end: assert property (s_rel_rise |-> ##[1:10] !exposure_active)
    else $error("pulse exposure outlived high level");
  chk_pulse_fall_end: assert property (s_rel_fall |-> ##[1:10] !exposure_active)
    else $error("pulse exposure outlived low level");
  chk_single_one_start: assert property (
    frame_start && !ctl[CTL_CONT] && !ctl[CTL_GATE] |-> since == 4'h0)
    else $error("second internal trigger in single shot");
  chk_rate_min_gap: assert property (
    frame_start && seen && !ctl[CTL_GATE] && ctl[CTL_CONT] |-> gap + 32'h4 >= eff_cyc)
    else $error("internal triggers closer than period");
endmodule
bind cftc_top cftc_props #(.W(W)) u_props (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .external_frame_trigger_in, .max_rate_period_us, .exposure_active,
  .trigger_ready_out, .frame_start);

// ===== tb/cftc_top_tb_top.sv
/*
  Self-checking bench for the frame trigger block, driven over APB.
  Assumes package, interfaces, design, source model and checker compile first.
*/
`timescale 1ns/10ps
module cftc_top_tb_top
  import cftc_pkg::*;
;
  logic ref_clk, srst, psel, penable, pwrite, fire, pol_fall, err, ra, rb;
  logic pready, pslverr, external_frame_trigger_in, exposure_active, trigger_ready_out;
  logic frame_start;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [SET_W-1:0] max_rate_period_us;
  logic [15:0] hi_len;
  int fail_count = 0, cmp_count = 0, nst = 0, lat, dur, per, n0;
  int ron[3] = '{0, 1, 1};
  int rates[3] = '{0, 5, 2};
  int pers[3] = '{3, 5, 3};
  cftc_top u_dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .external_frame_trigger_in, .max_rate_period_us, .exposure_active,
    .trigger_ready_out, .frame_start);
  cftc_trig_src u_src (.ref_clk, .fire, .pol_fall, .hi_len, .line(external_frame_trigger_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (frame_start === 1'b1) nst <= nst + 1;
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rng(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask
  // Latency is counted from the call, exposure length from the start pulse.
  task automatic run_frame();
    lat = 0;
    dur = 0;
    while (frame_start !== 1'b1 && lat < 3000) begin
      @(posedge ref_clk);
      lat++;
    end
    do begin
      @(posedge ref_clk);
      dur++;
      if (dur == 50) ra = trigger_ready_out;
      if (dur == 150) rb = trigger_ready_out;
    end while (exposure_active === 1'b1 && dur < 5000);
    if (lat >= 3000 || dur >= 5000) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic pulse_in();
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    run_frame();
  endtask
  initial begin
    {srst, psel, penable, pwrite, fire, pol_fall} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    hi_len = 16'h0014;
    max_rate_period_us = 24'h000003;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk(q, 32'h1);
    apb(8'h1c, 1'b1, 32'h5);
    chk({31'h0, err}, 32'h1);
    apb(OFF_SHUT, 1'b1, 32'h1);
    for (int i = 1; i <= 2; i++) begin
      apb(OFF_CMD, 1'b1, 32'h1);
      run_frame();
      repeat (600) @(posedge ref_clk);
      apb(OFF_FRAMES, 1'b0, 32'h0);
      chk(q, i);
    end
    for (int i = 0; i < 3; i++) begin
      apb(OFF_RATE, 1'b1, rates[i]);
      apb(OFF_CTRL, 1'b1, 32'h21 | (ron[i] << CTL_RATE_ON));
      apb(OFF_CMD, 1'b1, 32'h1);
      run_frame();
      per = dur;
      run_frame();
      per += lat;
      chk(rng(per, pers[i] * TICK_CYCLES - 3, pers[i] * TICK_CYCLES + 12), 32'h1);
      apb(OFF_CMD, 1'b1, 32'h2);
      repeat (200) @(posedge ref_clk);
      n0 = nst;
      repeat (1000) @(posedge ref_clk);
      chk(nst, n0);
    end
    for (int i = 0; i < 2; i++) begin
      pol_fall <= i[0];
      apb(OFF_LAT, 1'b1, 2 - 2 * i);
      apb(OFF_CTRL, 1'b1, 32'h23 | (i << CTL_POL_FALL));
      apb(OFF_CMD, 1'b1, 32'h1);
      pulse_in();
      chk(rng(lat, 200 - 200 * i, 215 - 200 * i), 32'h1);
      chk(rng(dur, 98, 106), 32'h1);
      apb(OFF_CMD, 1'b1, 32'h2);
    end
    hi_len <= 16'h012c;
    for (int i = 0; i < 2; i++) begin
      pol_fall <= i[0];
      apb(OFF_LAT, 1'b1, 32'h0);
      apb(OFF_CTRL, 1'b1, 32'h33 | (i << CTL_POL_FALL));
      apb(OFF_CMD, 1'b1, 32'h1);
      pulse_in();
      chk(rng(dur, 294, 306), 32'h1);
      chk({30'h0, ra, rb}, 32'h1);
      apb(OFF_CMD, 1'b1, 32'h2);
    end
    apb(OFF_LAT, 1'b1, 32'h3);
    apb(OFF_SHUT, 1'b1, 32'h3);
    apb(OFF_CTRL, 1'b1, 32'h27);
    apb(OFF_CMD, 1'b1, 32'h1);
    n0 = nst;
    apb(OFF_CMD, 1'b1, 32'h4);
    repeat (10) @(posedge ref_clk);
    chk(nst, n0 + 1);
    apb(OFF_CMD, 1'b1, 32'h4);
    repeat (400) @(posedge ref_clk);
    chk(nst, n0 + 1);
    report_and_stop();
  end
endmodule
